// ===== include/bcsa_defines.svh
// Constants shared by both ends of the brake configuration and status link
`ifndef BCSA_DEFINES_SVH
`define BCSA_DEFINES_SVH

// ==========================================================================
// Frame layout, sent least significant bit first
`define BCSA_FRAME_BITS      32
`define BCSA_ADDR_MSB        6
`define BCSA_MODE_BIT        7
`define BCSA_DATA_LSB        8
`define BCSA_DATA_MSB        23
`define BCSA_CRC_LSB         24
`define BCSA_CRC_MSB         31
`define BCSA_CRC_POLY        8'h1D
`define BCSA_CRC_INIT        8'hFF
// Zero response body with its CRC byte, so the first frame reports no error
`define BCSA_RESP_RESET      32'h0E00_0000

// ==========================================================================
// Register addresses
`define BCSA_ADDR_BRAKE      7'h1D
`define BCSA_ADDR_SUP        7'h40
`define BCSA_ADDR_THERM      7'h41
`define BCSA_ADDR_DEV        7'h42
`define BCSA_ADDR_WAKE       7'h44
`define BCSA_ADDR_WAKE_LVL   7'h45
`define BCSA_ADDR_GEN        7'h50
`define BCSA_ADDR_DELAY_REGULATION_STATUS      7'h51
`define BCSA_ADDR_DRAIN_SOURCE_OVERVOLTAGE_STATUS       7'h52
`define BCSA_ADDR_EFF1       7'h53
`define BCSA_ADDR_EFF2       7'h54
`define BCSA_ADDR_EFF3       7'h55
`define BCSA_ADDR_RISE1      7'h57
`define BCSA_ADDR_RISE2      7'h58
`define BCSA_ADDR_RISE3      7'h59
`define BCSA_ADDR_FAMILY     7'h70
`define BCSA_NUM_STATUS      15
`define BCSA_NO_INDEX        5'h1F

// ==========================================================================
// Brake control fields
`define BCSA_BRAKE_RESET     16'h00A0
`define BCSA_BRAKE_WMASK     16'h1FFF
`define BCSA_BRAKE_RESTART   16'h1FE7
`define BCSA_BRAKE_RSVD_MASK 16'hFFE7
`define BCSA_BIT_FORCED      9
`define BCSA_BIT_LOW1_DIS    10
`define BCSA_BIT_LOW3_DIS    12
`define BCSA_BIT_DS_THRESH   8
`define BCSA_BIT_BLANK       7
`define BCSA_BIT_PARK        6
`define BCSA_BIT_OV_EN       5
`define BCSA_OV_TH_MSB       2

// ==========================================================================
// Controller registers, word addresses on the Avalon-MM port
`define BCSA_REG_CMD         3'h0
`define BCSA_REG_STATUS      3'h1
`define BCSA_REG_RESPONSE    3'h2
`define BCSA_REG_IRQ_STATUS  3'h3
`define BCSA_REG_IRQ_ENABLE  3'h4
`define BCSA_REG_IRQ_CLEAR   3'h5
`define BCSA_IRQ_DONE        0
`define BCSA_IRQ_ERROR       1
`define BCSA_IRQ_BITS        2
`define BCSA_LINK_HALF       16

`endif

// ===== include/bcsa_pkg.sv
// Types and CRC helpers shared by both ends
`include "bcsa_defines.svh"

package bcsa_pkg;

    // ======================================================================
    // Controller link sequencer, Gray coded
    typedef enum logic [1:0] {
        HOST_IDLE  = 2'b00,
        HOST_SHIFT = 2'b01,
        HOST_HOLD  = 2'b11,
        HOST_GAP   = 2'b10
    } bcsa_host_state_type;

    typedef logic [15:0] bcsa_word_type;

    function automatic logic [7:0] bcsa_crc_step(input logic [7:0] c, input logic b);
        return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `BCSA_CRC_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] bcsa_crc24(input logic [23:0] d);
        logic [7:0] c;
        c = `BCSA_CRC_INIT;
        for (int i = 0; i < 24; i++) begin
            c = bcsa_crc_step(c, d[i]);
        end
        return c;
    endfunction

endpackage

// ===== include/bcsa_link_if.sv
// Four-wire serial link between controller and bridge driver register bank
`timescale 1ns/10ps

interface bcsa_link_if;
    logic chip_select_n;
    logic sclk;
    logic mosi;
    logic miso;

    modport dev (
        input  chip_select_n,
        input  sclk,
        input  mosi,
        output miso
    );

    modport host (
        output chip_select_n,
        output sclk,
        output mosi,
        input  miso
    );
endinterface

// ===== logic/bcsa_device.sv
// Bridge driver register bank: brake control and status access over the serial link
// Function
// - Bit 9 turns forced brake on.
// - Bits 10-12 drop low switch control in forced brake.
// - Bit 8 picks braking drain-source threshold.
// - Bit 7 picks braking blank time, default long.
// - Bit 6 enables parking brake, reset off.
// - Bit 5 enables overvoltage brake, reset on.
// - Bits 2:0 pick overvoltage brake trip level.
// - Controller writes zero into bits 4:3.
// - Bits 15:13 read as zero.
// - Reset loads 0x00A0; restart clears reserved bits.
// - Frame: address, mode bit, two data bytes, CRC.
// - Register data sits at frame bits 8-23.
// - Status bits are read-only or read-clear.
// - Mode zero reads without changing anything.
// - Mode one on a status address clears that word's clearable bits, ignores data.
// - Read-clear status bits hold until cleared.
// - Controller clears latched status by command.
// - Status decoded one word per address.
`timescale 1ns/10ps
`include "bcsa_defines.svh"

module bcsa_device #(
    parameter logic [15:0]                      FAMILY_ID = 16'h005A, // Arbitrary value
    parameter logic [`BCSA_NUM_STATUS*16-1:0]   RC_MASK   = {`BCSA_NUM_STATUS{16'hFFFF}}
) (
    input  wire logic                           CLK,
    input  wire logic                           RESET_N,
    input  wire logic                           CE,
    bcsa_link_if.dev                            LINK,
    input  wire logic                           SOFT_RESET,
    input  wire logic                           RESTART,
    input  wire logic [`BCSA_NUM_STATUS*16-1:0] STATUS_EVENT,
    input  wire logic [`BCSA_NUM_STATUS*16-1:0] STATUS_LEVEL,
    output logic                                FORCED_BRAKE_ENABLE,
    output logic [2:0]                          FORCED_BRAKE_LOW_DISABLE,
    output logic                                BRAKE_DRAIN_SOURCE_THRESHOLD,
    output logic                                BRAKE_BLANK_TIME,
    output logic                                PARKING_BRAKE_ENABLE,
    output logic                                OVERVOLTAGE_BRAKE_ENABLE,
    output logic [2:0]                          OVERVOLTAGE_BRAKE_THRESHOLD
);

    // ======================================================================
    // Pin synchronisers
    logic        csn_s1;
    logic        csn_s2;
    logic        csn_q;
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_q;
    logic        mosi_s1;
    logic        mosi_s2;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            csn_s1  <= 1'b1;
            csn_s2  <= 1'b1;
            csn_q   <= 1'b1;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_q  <= 1'b0;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else if (CE) begin
            csn_s1  <= LINK.chip_select_n;
            csn_s2  <= csn_s1;
            csn_q   <= csn_s2;
            sclk_s1 <= LINK.sclk;
            sclk_s2 <= sclk_s1;
            sclk_q  <= sclk_s2;
            mosi_s1 <= LINK.mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    logic        frame_start;
    logic        frame_end;
    logic        sclk_rise;
    logic        sclk_fall;

    assign frame_start = csn_q & ~csn_s2;
    assign frame_end   = ~csn_q & csn_s2;
    assign sclk_rise   = ~sclk_q & sclk_s2 & ~csn_s2;
    assign sclk_fall   = sclk_q & ~sclk_s2 & ~csn_s2;

    // ======================================================================
    // Receive shifter and CRC check
    logic [31:0] rx_frame;
    logic [5:0]  bit_cnt;
    logic [7:0]  crc_rx;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_frame <= 32'h0000_0000;
            bit_cnt  <= 6'h00;
            crc_rx   <= `BCSA_CRC_INIT;
        end else if (CE) begin
            if (frame_start) begin
                bit_cnt <= 6'h00;
                crc_rx  <= `BCSA_CRC_INIT;
            end else if (sclk_rise && bit_cnt < 6'(`BCSA_FRAME_BITS)) begin
                rx_frame[bit_cnt[4:0]] <= mosi_s2;
                bit_cnt                <= bit_cnt + 6'h01;
                if (bit_cnt < 6'(`BCSA_CRC_LSB)) begin
                    crc_rx <= bcsa_pkg::bcsa_crc_step(crc_rx, mosi_s2);
                end
            end
        end
    end

    logic        frame_ok;
    logic        commit;
    logic [6:0]  req_addr;
    logic        req_mode;
    logic [15:0] req_data;

    // Short or corrupted frames change nothing; clocks after bit 32 are ignored
    assign frame_ok = (bit_cnt == 6'(`BCSA_FRAME_BITS))
                    && (crc_rx == rx_frame[`BCSA_CRC_MSB:`BCSA_CRC_LSB]);
    assign commit   = CE & frame_end & frame_ok;
    assign req_addr = rx_frame[`BCSA_ADDR_MSB:0];
    assign req_mode = rx_frame[`BCSA_MODE_BIT];
    assign req_data = rx_frame[`BCSA_DATA_MSB:`BCSA_DATA_LSB];

    // ======================================================================
    // Status address decode
    function automatic logic [4:0] status_index(input logic [6:0] a);
        case (a)
            `BCSA_ADDR_SUP:      return 5'h00;
            `BCSA_ADDR_THERM:    return 5'h01;
            `BCSA_ADDR_DEV:      return 5'h02;
            `BCSA_ADDR_WAKE:     return 5'h03;
            `BCSA_ADDR_WAKE_LVL: return 5'h04;
            `BCSA_ADDR_GEN:      return 5'h05;
            `BCSA_ADDR_DELAY_REGULATION_STATUS:    return 5'h06;
            `BCSA_ADDR_DRAIN_SOURCE_OVERVOLTAGE_STATUS:     return 5'h07;
            `BCSA_ADDR_EFF1:     return 5'h08;
            `BCSA_ADDR_EFF2:     return 5'h09;
            `BCSA_ADDR_EFF3:     return 5'h0A;
            `BCSA_ADDR_RISE1:    return 5'h0B;
            `BCSA_ADDR_RISE2:    return 5'h0C;
            `BCSA_ADDR_RISE3:    return 5'h0D;
            default:             return `BCSA_NO_INDEX;
        endcase
    endfunction

    logic [4:0]  req_index;

    assign req_index = status_index(req_addr);

    // ======================================================================
    // Status registers
    logic [15:0] status_latch [`BCSA_NUM_STATUS];
    logic [15:0] status_value [`BCSA_NUM_STATUS];

    genvar gi;
    generate
        for (gi = 0; gi < `BCSA_NUM_STATUS; gi++) begin : g_status
            logic [15:0] rc;
            logic [15:0] clear_mask;

            assign rc         = RC_MASK[gi*16 +: 16];
            // Whole-word clear, data bits never select
            assign clear_mask = (commit && req_mode && req_index == 5'(gi)) ? rc : 16'h0000;

            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    status_latch[gi] <= 16'h0000;
                end else if (CE) begin
                    // New events win over a clear in the same cycle
                    status_latch[gi] <= (status_latch[gi] & ~clear_mask)
                                      | (STATUS_EVENT[gi*16 +: 16] & rc);
                end
            end

            assign status_value[gi] = (status_latch[gi] & rc)
                                    | (STATUS_LEVEL[gi*16 +: 16] & ~rc);
        end
    endgenerate

    // ======================================================================
    // Brake control register
    logic [15:0] brake;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            brake <= `BCSA_BRAKE_RESET;
        end else if (CE) begin
            if (SOFT_RESET) begin
                brake <= `BCSA_BRAKE_RESET;
            end else if (RESTART) begin
                brake <= brake & `BCSA_BRAKE_RESTART;
            end else if (commit && req_mode && req_addr == `BCSA_ADDR_BRAKE) begin
                brake <= req_data & `BCSA_BRAKE_WMASK;
            end
        end
    end

    assign FORCED_BRAKE_ENABLE          = brake[`BCSA_BIT_FORCED];
    assign FORCED_BRAKE_LOW_DISABLE     = brake[`BCSA_BIT_LOW3_DIS:`BCSA_BIT_LOW1_DIS];
    assign BRAKE_DRAIN_SOURCE_THRESHOLD = brake[`BCSA_BIT_DS_THRESH];
    assign BRAKE_BLANK_TIME             = brake[`BCSA_BIT_BLANK];
    assign PARKING_BRAKE_ENABLE         = brake[`BCSA_BIT_PARK];
    assign OVERVOLTAGE_BRAKE_ENABLE     = brake[`BCSA_BIT_OV_EN];
    assign OVERVOLTAGE_BRAKE_THRESHOLD  = brake[`BCSA_OV_TH_MSB:0];

    // ======================================================================
    // Response of the previous frame, shifted out during the next one
    logic [15:0] read_data;
    logic [23:0] resp_body;
    logic [31:0] resp;

    always_comb begin
        if (req_addr == `BCSA_ADDR_BRAKE) begin
            read_data = brake;
        end else if (req_addr == `BCSA_ADDR_FAMILY) begin
            read_data = FAMILY_ID;
        end else if (req_index != `BCSA_NO_INDEX) begin
            read_data = status_value[req_index[3:0]];
        end else begin
            read_data = 16'h0000;
        end
    end

    assign resp_body = frame_ok ? {read_data, 1'b0, req_addr} : {16'h0000, 1'b1, req_addr};

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            resp <= `BCSA_RESP_RESET;
        end else if (CE && frame_end) begin
            resp <= {bcsa_pkg::bcsa_crc24(resp_body), resp_body};
        end
    end

    logic        miso;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            miso <= 1'b0;
        end else if (CE) begin
            if (frame_start) begin
                miso <= resp[0];
            end else if (sclk_fall && bit_cnt < 6'(`BCSA_FRAME_BITS)) begin
                miso <= resp[bit_cnt[4:0]];
            end
        end
    end

    assign LINK.miso = miso;

endmodule

// ===== logic/bcsa_host.sv
// Link controller: Avalon-MM command registers driving the serial link
`timescale 1ns/10ps
`include "bcsa_defines.svh"

module bcsa_host #(
    parameter int HALF_PERIOD = `BCSA_LINK_HALF
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    bcsa_link_if.host        LINK,
    input  wire logic [2:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             IRQ
);

    generate
        if (HALF_PERIOD < 4 || HALF_PERIOD > 255) begin : g_check
            $error("HALF_PERIOD must lie between 4 and 255");
        end
    endgenerate

    // ======================================================================
    // Avalon-MM slave, one wait cycle on every access
    logic        access;

    assign access = CE & (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;

    bcsa_pkg::bcsa_host_state_type state;
    logic [31:0] response;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
        end else if (CE) begin
            AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
            case (AVS_ADDRESS)
                `BCSA_REG_STATUS:     AVS_READDATA <= {31'h0, state != bcsa_pkg::HOST_IDLE};
                `BCSA_REG_RESPONSE:   AVS_READDATA <= response;
                `BCSA_REG_IRQ_STATUS: AVS_READDATA <= {30'h0, irq_status};
                `BCSA_REG_IRQ_ENABLE: AVS_READDATA <= {30'h0, irq_enable};
                default:              AVS_READDATA <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_enable <= 2'h0;
        end else if (access && AVS_WRITE && AVS_ADDRESS == `BCSA_REG_IRQ_ENABLE) begin
            irq_enable <= AVS_WRITEDATA[`BCSA_IRQ_BITS-1:0];
        end
    end

    // ======================================================================
    // Link sequencer
    logic        miso_s1;
    logic        miso_s2;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [7:0]  div;
    logic [4:0]  bit_idx;
    logic        start;
    logic [23:0] cmd_body;
    logic        done_pulse;
    logic        error_flag;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else if (CE) begin
            miso_s1 <= LINK.miso;
            miso_s2 <= miso_s1;
        end
    end

    // Commands while a frame runs are dropped
    assign start = access & AVS_WRITE & (AVS_ADDRESS == `BCSA_REG_CMD)
                 & (state == bcsa_pkg::HOST_IDLE);
    assign cmd_body = {AVS_WRITEDATA[`BCSA_DATA_MSB:`BCSA_DATA_LSB]
                       & ((AVS_WRITEDATA[`BCSA_ADDR_MSB:0] == `BCSA_ADDR_BRAKE)
                          ? `BCSA_BRAKE_RSVD_MASK : 16'hFFFF),
                       AVS_WRITEDATA[`BCSA_MODE_BIT:0]};

    logic        csn;
    logic        sclk;
    logic        mosi;
    logic        half_done;

    assign half_done = (div == 8'(HALF_PERIOD - 1));

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state      <= bcsa_pkg::HOST_IDLE;
            csn        <= 1'b1;
            sclk       <= 1'b0;
            mosi       <= 1'b0;
            tx         <= 32'h0000_0000;
            rx         <= 32'h0000_0000;
            response   <= 32'h0000_0000;
            div        <= 8'h00;
            bit_idx    <= 5'h00;
            done_pulse <= 1'b0;
        end else if (CE) begin
            done_pulse <= 1'b0;
            div        <= half_done ? 8'h00 : div + 8'h01;
            case (state)
                bcsa_pkg::HOST_IDLE: begin
                    div <= 8'h00;
                    if (start) begin
                        tx      <= {bcsa_pkg::bcsa_crc24(cmd_body), cmd_body};
                        mosi    <= cmd_body[0];
                        csn     <= 1'b0;
                        bit_idx <= 5'h00;
                        state   <= bcsa_pkg::HOST_SHIFT;
                    end
                end
                bcsa_pkg::HOST_SHIFT: begin
                    if (half_done && !sclk) begin
                        sclk <= 1'b1;
                    end else if (half_done) begin
                        // Sampled late in the high phase, after sync delay
                        rx[bit_idx] <= miso_s2;
                        sclk        <= 1'b0;
                        if (bit_idx == 5'(`BCSA_FRAME_BITS - 1)) begin
                            state <= bcsa_pkg::HOST_HOLD;
                        end else begin
                            bit_idx <= bit_idx + 5'h01;
                            mosi    <= tx[bit_idx + 5'h01];
                        end
                    end
                end
                bcsa_pkg::HOST_HOLD: begin
                    if (half_done) begin
                        csn   <= 1'b1;
                        state <= bcsa_pkg::HOST_GAP;
                    end
                end
                bcsa_pkg::HOST_GAP: begin
                    if (half_done) begin
                        response   <= rx;
                        done_pulse <= 1'b1;
                        state      <= bcsa_pkg::HOST_IDLE;
                    end
                end
                default: state <= bcsa_pkg::HOST_IDLE;
            endcase
        end
    end

    assign LINK.chip_select_n = csn;
    assign LINK.sclk          = sclk;
    assign LINK.mosi          = mosi;

    // ======================================================================
    // Interrupts: set wins over a clear in the same cycle
    assign error_flag = rx[`BCSA_MODE_BIT]
                      | (bcsa_pkg::bcsa_crc24(rx[23:0]) != rx[`BCSA_CRC_MSB:`BCSA_CRC_LSB]);

    logic [1:0]  irq_set;
    logic [1:0]  irq_clr;

    assign irq_set = {done_pulse & error_flag, done_pulse};
    assign irq_clr = (access && AVS_WRITE && AVS_ADDRESS == `BCSA_REG_IRQ_CLEAR)
                   ? AVS_WRITEDATA[`BCSA_IRQ_BITS-1:0] : 2'h0;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_status <= 2'h0;
            IRQ        <= 1'b0;
        end else if (CE) begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            IRQ        <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
        end
    end

endmodule

// ===== verif/bcsa_link_sva.sv
// Protocol checker for the serial link
`timescale 1ns/10ps
module bcsa_link_sva #(
    parameter int HALF_PERIOD = 16
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso
);
    // ==========
    // Framing
    logic [5:0] rises;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) rises <= 6'h00;
        else if (chip_select_n) rises <= 6'h00;
        else if ($rose(sclk)) rises <= rises + 6'h01;
    end
    idle_clock_low_a: assert property (chip_select_n |-> !sclk)
        else $error("clock toggles while deselected");
    bit_count_a: assert property ($rose(chip_select_n) |-> rises == 6'h20)
        else $error("frame is not 32 pulses");
    high_phase_a: assert property (
        $rose(sclk) |-> ##[HALF_PERIOD:HALF_PERIOD] $fell(sclk))
        else $error("clock high phase length wrong");
    mosi_steady_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("mosi moved in high phase");
    miso_steady_a: assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("miso moved in high phase");
    select_lead_a: assert property (
        $fell(chip_select_n) |-> (!chip_select_n && !sclk)[*8])
        else $error("clock too soon after select");
    frame_gap_a: assert property ($rose(chip_select_n) |-> chip_select_n[*8])
        else $error("gap between frames too short");
    last_hold_a: assert property (
        $fell(sclk) && rises == 6'h20 |-> ##[HALF_PERIOD:HALF_PERIOD] $rose(chip_select_n))
        else $error("deselect not one half period after last bit");
    cover property ($fell(chip_select_n));
    cover property ($rose(chip_select_n));
    cover property (sclk && miso);
endmodule

// ===== verif/tb_brake_config_status_access.sv
// Bench joining controller and register bank over the link
`timescale 1ns/10ps
module tb_brake_config_status_access;
    localparam logic [15:0] FAMILY_ID = 16'h0A5C; // Arbitrary value
    // Bits 14:13 of the first status word are read-only live levels
    localparam logic [239:0] RC_MASK = {{14{16'hFFFF}}, 16'h9FFF};
    logic         clk = 1'b0;
    logic         reset_n = 1'b0;
    logic         soft_reset = 1'b0;
    logic         restart = 1'b0;
    logic [239:0] status_event = 240'h0;
    logic [239:0] status_level = 240'h0;
    logic [2:0]   avs_address = 3'h0;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [31:0]  avs_readdata, rd;
    logic         avs_waitrequest, irq, forced, ds_th, blank, park, ov_en;
    logic [2:0]   low_dis, ov_th;
    logic [6:0]   pa = 7'h00;
    logic [15:0]  d, e, p;
    int           errors = 0;
    int           checks = 0;
    int           cycles = 0;
    logic [6:0]   ta [7] = '{7'h40, 7'h40, 7'h59, 7'h40, 7'h70, 7'h43, 7'h1D};
    logic [15:0]  te [7] = '{16'hA001, 16'hA001, 16'hA001, 16'h4002, 16'h2000,
                             FAMILY_ID, 16'h0000};
    wire  [15:0]  brake_out = {3'h0, low_dis, forced, ds_th, blank, park, ov_en, 2'h0, ov_th};

    // ==========
    // Ends and checker
    bcsa_link_if link ();
    bcsa_host #(.HALF_PERIOD(16)) i_bcsa_host (.CLK(clk), .RESET_N(reset_n), .CE(1'b1),
        .LINK(link), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq));
    bcsa_device #(.FAMILY_ID(FAMILY_ID), .RC_MASK(RC_MASK)) i_bcsa_device (.CLK(clk),
        .RESET_N(reset_n), .CE(1'b1), .LINK(link), .SOFT_RESET(soft_reset), .RESTART(restart),
        .STATUS_EVENT(status_event), .STATUS_LEVEL(status_level), .FORCED_BRAKE_ENABLE(forced),
        .FORCED_BRAKE_LOW_DISABLE(low_dis), .BRAKE_DRAIN_SOURCE_THRESHOLD(ds_th),
        .BRAKE_BLANK_TIME(blank), .PARKING_BRAKE_ENABLE(park),
        .OVERVOLTAGE_BRAKE_ENABLE(ov_en), .OVERVOLTAGE_BRAKE_THRESHOLD(ov_th));
    bcsa_link_sva #(.HALF_PERIOD(16)) i_bcsa_link_sva (.CLK(clk), .RESET_N(reset_n),
        .chip_select_n(link.chip_select_n), .sclk(link.sclk), .mosi(link.mosi),
        .miso(link.miso));

    always #2 clk = ~clk;

    // ==========
    // Tasks
    task automatic wrap_up();
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic av(input logic [2:0] a, input logic w, input logic [31:0] wd);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    // Response shows the previous frame, so the expectation lags by one
    task automatic fr(input logic [6:0] a, input logic m, input logic [15:0] dd,
                      input logic [15:0] x);
        av(3'h0, 1'b1, {8'h00, dd, m, a});
        do av(3'h1, 1'b0, 32'h0); while (rd[0] !== 1'b0);
        av(3'h2, 1'b0, 32'h0);
        chk({8'h00, rd[23:0]}, {8'h00, x, 1'b0, pa});
        pa = a;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            wrap_up();
        end
    end

    // ==========
    // Sequence
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk(brake_out, 32'h00A0);
        fr(7'h1D, 1'b0, 16'h0000, 16'h0000);
        p = 16'h00A0;
        e = p;
        for (int i = 0; i < 8; i++) begin
            d = {{13{i[0]}}, i[2:0]};
            fr(7'h1D, 1'b1, d, p);
            p = e;
            e = d & 16'h1FE7;
            chk(brake_out, e);
        end
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        repeat (2) @(posedge clk);
        chk(brake_out, e);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk(brake_out, 32'h00A0);
        status_event <= {16'h0000, 16'h4002, 192'h0, 16'h8001};
        status_level <= {224'h0, 16'h2000};
        @(posedge clk);
        status_event <= 240'h0;
        fr(7'h40, 1'b0, 16'h0000, p);
        for (int i = 0; i < 7; i++) fr(ta[i], i == 1, {16{i == 1}}, te[i]);
        av(3'h3, 1'b0, 32'h0);
        chk(rd, 32'h1);
        av(3'h5, 1'b1, 32'h3);
        av(3'h4, 1'b1, 32'h1);
        av(3'h4, 1'b0, 32'h0);
        chk(rd, 32'h1);
        chk(irq, 32'h0);
        fr(7'h70, 1'b0, 16'h0000, 16'h00A0);
        av(3'h3, 1'b0, 32'h0);
        chk(irq, 32'h1);
        av(3'h5, 1'b1, 32'h1);
        av(3'h4, 1'b1, 32'h0);
        chk(irq, 32'h0);
        fr(7'h1D, 1'b0, 16'h0000, FAMILY_ID);
        av(3'h3, 1'b0, 32'h0);
        chk(rd, 32'h1);
        chk(irq, 32'h0);
        av(3'h7, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule
